// *** design/lbd_defs.svh ***
// Address map, file-space locations, opcode fields and reset values of the decoder.
`ifndef LBD_DEFS_SVH
`define LBD_DEFS_SVH
`define LBD_A_INSTR   8'h00
`define LBD_A_ACC     8'h04
`define LBD_A_STATUS  8'h08
`define LBD_A_PC      8'h0C
`define LBD_A_CTRL    8'h10
`define LBD_A_PDIR    8'h14
`define LBD_A_FADDR   8'h18
`define LBD_A_FDATA   8'h1C
`define LBD_A_TIMERS  8'h20
`define LBD_A_STACK   8'h24
`define LBD_F_TIMER0  7'h01
`define LBD_F_STATUS  7'h03
`define LBD_F_PORT    7'h06
`define LBD_F_PCHI    7'h0A
`define LBD_ST_RESET  5'h18
`define LBD_PDIR_RESET 8'hFF
`define LBD_CTRL_PSA  0
`define LBD_CTRL_STBY 1
`define LBD_C_BYTE    2'h0
`define LBD_C_BIT     2'h1
`define LBD_C_BRANCH  2'h2
`define LBD_C_LIT     2'h3
`define LBD_L_MOV     2'h0
`define LBD_L_RET     2'h1
`define LBD_L_IOR     4'h8
`define LBD_L_AND     4'h9
`define LBD_L_XOR     4'hA
`define LBD_L_SUB     3'h6
`define LBD_L_ADD     3'h7
`define LBD_B_ADD     4'h7
`define LBD_B_AND     4'h5
`define LBD_B_CLR     4'h1
`define LBD_BO_CLR    2'h0
`define LBD_BO_SET    2'h1
`define LBD_BO_SKC    2'h2
`define LBD_BO_SKS    2'h3
`define LBD_W_RET     14'h0008
`define LBD_W_RETI    14'h0009
`define LBD_W_SLEEP   14'h0063
`define LBD_W_WDTR    14'h0064
`endif

// *** design/lbd_pkg.sv ***
// Types shared by the literal and bit operation decoder.
`default_nettype none
package lbd_pkg;
    typedef enum logic [4:0] {
        LBD_OP_IDLE     = 5'b00000,
        LBD_OP_MOV_LIT  = 5'b00001,
        LBD_OP_RET_LIT  = 5'b00010,
        LBD_OP_OR_LIT   = 5'b00011,
        LBD_OP_AND_LIT  = 5'b00100,
        LBD_OP_XOR_LIT  = 5'b00101,
        LBD_OP_SUB_LIT  = 5'b00110,
        LBD_OP_ADD_LIT  = 5'b00111,
        LBD_OP_CALL     = 5'b01000,
        LBD_OP_JUMP     = 5'b01001,
        LBD_OP_ADD_FILE = 5'b01010,
        LBD_OP_AND_FILE = 5'b01011,
        LBD_OP_CLR_FILE = 5'b01100,
        LBD_OP_BIT_CLR  = 5'b01101,
        LBD_OP_BIT_SET  = 5'b01110,
        LBD_OP_SKIP_CLR = 5'b01111,
        LBD_OP_SKIP_SET = 5'b10000,
        LBD_OP_RETURN   = 5'b10001,
        LBD_OP_RET_INT  = 5'b10010,
        LBD_OP_SLEEP    = 5'b10011,
        LBD_OP_WDT_RST  = 5'b10100
    } lbd_op_t;

    // Status bits, most significant first, matching the software view.
    typedef struct packed {
        logic watchdog_expiry_flag;
        logic sleep_entered_flag;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } lbd_status_t;
endpackage
`default_nettype wire

// *** design/lbd_core.sv ***
// Literal, control and bit operation decoder with its AHB-Lite register slave.
// Notes on behaviour
// RL1: add literal to accumulator, flags C DC Z.
// RL2: AND literal into accumulator, zero flag only.
// RL3: call pushes return, loads target, two cycles.
// RL4: OR literal into accumulator, one cycle.
// RL5: XOR literal into accumulator, one cycle.
// RL6: literal minus accumulator, flags C DC Z.
// RL7: returns pop stack, literal return loads accumulator.
// RL8: sleep enters standby, updates expiry and sleep.
// RL9: port self-modify reads input pins, not latch; bits set as outputs read the latch instead.
// RL10: timer0 write clears prescaler when assigned there.
// RL11: branches and true skips take two cycles.
// RL12: add accumulator and file, destination bit routes.
// RL13: AND accumulator and file, routed, zero flag.
// RL14: clear chosen file bit, flags untouched.
// RL15: set chosen file bit, flags untouched.
// RL16: skip next instruction when bit is clear.
// RL17: skip next instruction when bit is set.
// RL18: clear file register and set zero flag.
// RL19: watchdog restart zeroes watchdog, and prescaler when assigned there, sets both flags.
// RL20: jump loads target without stack, two cycles.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "lbd_defs.svh"
module lbd_core
    import lbd_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int PRESC_W     = 8,
    parameter int WDT_W       = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  port_pins_in,
    output logic      [7:0]  port_out,
    output logic      [7:0]  port_oe_n,
    output logic             standby
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    // Registers of the core state.
    logic [7:0]         acc_r;
    lbd_status_t        status_r;
    logic [12:0]        pc_r;
    logic [4:0]         pc_high_latch_r;
    logic [7:0]         timer0_r;
    logic [PRESC_W-1:0] presc_r;
    logic [WDT_W-1:0]   wdt_r;
    logic [7:0]         port_lat_r;
    logic [7:0]         port_dir_r;
    logic               psa_r;
    logic               sleep_r;
    logic [6:0]         faddr_r;
    logic [SP_W-1:0]    sp_r;
    logic [12:0]        stack_mem [STACK_DEPTH];
    logic [7:0]         file_mem [128];
    logic [7:0]         pin_meta_r;
    logic [7:0]         pin_sync_r;
    logic               dph_wr_r;
    logic               dph_rd_r;
    logic [7:0]         dph_addr_r;
    logic               hreadyout_r;
    logic [31:0]        hrdata_r;

    // File view: special locations map onto live registers.
    function automatic logic [7:0] file_view(
        input logic [6:0]  a,
        input logic [7:0]  memv,
        input logic [7:0]  tmr,
        input logic [7:0]  prt,
        input logic [4:0]  plh,
        input lbd_status_t st
    );
        logic [7:0] v;
        v = memv;
        if (a == `LBD_F_TIMER0) begin
            v = tmr;
        end else if (a == `LBD_F_PORT) begin
            v = prt;
        end else if (a == `LBD_F_PCHI) begin
            v = {3'h0, plh};
        end else if (a == `LBD_F_STATUS) begin
            v = {3'h0, st};
        end
        return v;
    endfunction

    // Pin inputs come from outside the clock domain: two flip-flops first.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end else begin
            pin_meta_r <= port_pins_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Bus address phase capture and data phase qualifiers.
    wire       addr_take = hsel & htrans[1] & hready;
    wire       wr_do     = hready & dph_wr_r;
    wire       exec      = wr_do & (dph_addr_r == `LBD_A_INSTR) & ~sleep_r;
    wire       bus_wr    = wr_do & ~exec;

    // Instruction fields.
    wire [13:0] ir    = hwdata[13:0];
    wire [7:0]  k8    = ir[7:0];
    wire [10:0] k11   = ir[10:0];
    wire [6:0]  fa    = ir[6:0];
    wire        dest  = ir[7];
    wire [2:0]  bsel  = ir[9:7];
    wire [1:0]  cls   = ir[13:12];

    // Opcode decode; unknown words fall through to an idle cycle.
    // RL1 RL2 RL4 RL5 RL6 literal groups.
    wire lit_mov = (cls == `LBD_C_LIT) & (ir[11:10] == `LBD_L_MOV);
    wire lit_ret = (cls == `LBD_C_LIT) & (ir[11:10] == `LBD_L_RET);
    wire lit_ior = (cls == `LBD_C_LIT) & (ir[11:8] == `LBD_L_IOR);
    wire lit_and = (cls == `LBD_C_LIT) & (ir[11:8] == `LBD_L_AND);
    wire lit_xor = (cls == `LBD_C_LIT) & (ir[11:8] == `LBD_L_XOR);
    wire lit_sub = (cls == `LBD_C_LIT) & (ir[11:9] == `LBD_L_SUB);
    wire lit_add = (cls == `LBD_C_LIT) & (ir[11:9] == `LBD_L_ADD);
    wire byt_add = (cls == `LBD_C_BYTE) & (ir[11:8] == `LBD_B_ADD);
    wire byt_and = (cls == `LBD_C_BYTE) & (ir[11:8] == `LBD_B_AND);
    wire byt_clr = (cls == `LBD_C_BYTE) & (ir[11:8] == `LBD_B_CLR) & dest;
    wire is_bit  = (cls == `LBD_C_BIT);
    wire is_br   = (cls == `LBD_C_BRANCH);
    lbd_op_t op;
    assign op = lit_mov ? LBD_OP_MOV_LIT :
                lit_ret ? LBD_OP_RET_LIT :
                lit_ior ? LBD_OP_OR_LIT :
                lit_and ? LBD_OP_AND_LIT :
                lit_xor ? LBD_OP_XOR_LIT :
                lit_sub ? LBD_OP_SUB_LIT :
                lit_add ? LBD_OP_ADD_LIT :
                (is_br & ~ir[11]) ? LBD_OP_CALL :
                (is_br & ir[11]) ? LBD_OP_JUMP :
                byt_add ? LBD_OP_ADD_FILE :
                byt_and ? LBD_OP_AND_FILE :
                byt_clr ? LBD_OP_CLR_FILE :
                (is_bit & (ir[11:10] == `LBD_BO_CLR)) ? LBD_OP_BIT_CLR :
                (is_bit & (ir[11:10] == `LBD_BO_SET)) ? LBD_OP_BIT_SET :
                (is_bit & (ir[11:10] == `LBD_BO_SKC)) ? LBD_OP_SKIP_CLR :
                (is_bit & (ir[11:10] == `LBD_BO_SKS)) ? LBD_OP_SKIP_SET :
                (ir == `LBD_W_RET) ? LBD_OP_RETURN :
                (ir == `LBD_W_RETI) ? LBD_OP_RET_INT :
                (ir == `LBD_W_SLEEP) ? LBD_OP_SLEEP :
                (ir == `LBD_W_WDTR) ? LBD_OP_WDT_RST : LBD_OP_IDLE;

    // RL9 port pins read back
    wire [7:0] port_view = (port_dir_r & pin_sync_r) | (~port_dir_r & port_lat_r);
    wire [7:0] fval  = file_view(fa, file_mem[fa], timer0_r, port_view, pc_high_latch_r, status_r);
    wire [7:0] fdata = file_view(faddr_r, file_mem[faddr_r], timer0_r, port_view,
                                 pc_high_latch_r, status_r);

    // Arithmetic: one adder for sums, one for literal minus accumulator.
    wire [7:0] opnd  = ir[13] ? k8 : fval;
    wire [8:0] sum9  = {1'b0, acc_r} + {1'b0, opnd};
    wire [4:0] dsum  = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]};
    wire [8:0] sub9  = {1'b0, opnd} + {1'b0, ~acc_r} + 9'h001;
    wire [4:0] dsub  = {1'b0, opnd[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;
    wire [7:0] bmask = 8'h01 << bsel;
    wire       bval  = fval[bsel];

    // Result, destinations and flag effects of the executing word.
    logic [7:0]  res;
    logic        w_acc;
    logic        w_file;
    logic        upd_z;
    logic        upd_cdc;
    logic        cy;
    logic        dcy;
    logic        two_cyc;
    logic        push;
    logic        pop;
    logic [12:0] pc_nxt;
    always_comb begin
        res     = acc_r;
        w_acc   = 1'b0;
        w_file  = 1'b0;
        upd_z   = 1'b0;
        upd_cdc = 1'b0;
        cy      = sum9[8];
        dcy     = dsum[4];
        two_cyc = 1'b0;
        push    = 1'b0;
        pop     = 1'b0;
        pc_nxt  = pc_r + 13'h0001;
        case (op)
            // RL1 literal add
            LBD_OP_ADD_LIT: begin
                res = sum9[7:0]; w_acc = 1'b1; upd_z = 1'b1; upd_cdc = 1'b1;
            end
            // RL2 literal AND
            LBD_OP_AND_LIT: begin
                res = acc_r & k8; w_acc = 1'b1; upd_z = 1'b1;
            end
            // RL4 literal OR
            LBD_OP_OR_LIT: begin
                res = acc_r | k8; w_acc = 1'b1; upd_z = 1'b1;
            end
            // RL5 literal XOR
            LBD_OP_XOR_LIT: begin
                res = acc_r ^ k8; w_acc = 1'b1; upd_z = 1'b1;
            end
            // RL6 literal minus accumulator
            LBD_OP_SUB_LIT: begin
                res = sub9[7:0]; w_acc = 1'b1; upd_z = 1'b1; upd_cdc = 1'b1;
                cy = sub9[8]; dcy = dsub[4];
            end
            LBD_OP_MOV_LIT: begin
                res = k8; w_acc = 1'b1;
            end
            // RL7 return loads literal
            LBD_OP_RET_LIT: begin
                res = k8; w_acc = 1'b1; pop = 1'b1; two_cyc = 1'b1;
                pc_nxt = stack_mem[SP_W'(sp_r - 1'b1)];
            end
            // RL7 plain and interrupt returns
            LBD_OP_RETURN, LBD_OP_RET_INT: begin
                pop = 1'b1; two_cyc = 1'b1;
                pc_nxt = stack_mem[SP_W'(sp_r - 1'b1)];
            end
            // RL3 call target
            LBD_OP_CALL: begin
                push = 1'b1; two_cyc = 1'b1; pc_nxt = {pc_high_latch_r[4:3], k11};
            end
            // RL20 jump target
            LBD_OP_JUMP: begin
                two_cyc = 1'b1; pc_nxt = {pc_high_latch_r[4:3], k11};
            end
            // RL12 add with routing
            LBD_OP_ADD_FILE: begin
                res = sum9[7:0]; w_acc = ~dest; w_file = dest;
                upd_z = 1'b1; upd_cdc = 1'b1;
            end
            // RL13 AND with routing
            LBD_OP_AND_FILE: begin
                res = acc_r & fval; w_acc = ~dest; w_file = dest; upd_z = 1'b1;
            end
            // RL18 clear file
            LBD_OP_CLR_FILE: begin
                res = 8'h00; w_file = 1'b1; upd_z = 1'b1;
            end
            // RL14 bit clear
            LBD_OP_BIT_CLR: begin
                res = fval & ~bmask; w_file = 1'b1;
            end
            // RL15 bit set
            LBD_OP_BIT_SET: begin
                res = fval | bmask; w_file = 1'b1;
            end
            // RL16 skip on clear
            LBD_OP_SKIP_CLR: begin
                two_cyc = ~bval;
                pc_nxt = bval ? pc_r + 13'h0001 : pc_r + 13'h0002;
            end
            // RL17 skip on set
            LBD_OP_SKIP_SET: begin
                two_cyc = bval;
                pc_nxt = bval ? pc_r + 13'h0002 : pc_r + 13'h0001;
            end
            default: begin
                res = acc_r;
            end
        endcase
    end

    // One file write port shared by instructions and the bus window.
    wire       fw_bus  = bus_wr & (dph_addr_r == `LBD_A_FDATA);
    wire       fw_en   = (exec & w_file) | fw_bus;
    wire [6:0] fw_addr = fw_bus ? faddr_r : fa;
    wire [7:0] fw_data = fw_bus ? hwdata[7:0] : res;
    // RL10 prescaler cleared on timer0 write
    wire       tmr_wr  = fw_en & (fw_addr == `LBD_F_TIMER0);
    wire       presc_clr = (tmr_wr & ~psa_r) | (exec & (op == LBD_OP_WDT_RST) & psa_r);
    wire       presc_ov  = &presc_r;
    wire       wdt_tick  = psa_r ? presc_ov : 1'b1;
    wire       wdt_ov    = wdt_tick & (&wdt_r);

    // Plain file memory has no reset; special locations live elsewhere.
    always_ff @(posedge hclk) begin
        if (fw_en) begin
            file_mem[fw_addr] <= fw_data;
        end
        if (exec & push) begin
            stack_mem[sp_r] <= pc_r + 13'h0001;
        end
    end

    // Status flags: bus write, file write, then instruction effects.
    lbd_status_t st_nxt;
    always_comb begin
        st_nxt = status_r;
        if (bus_wr & (dph_addr_r == `LBD_A_STATUS)) begin
            st_nxt = lbd_status_t'(hwdata[4:0]);
        end
        if (fw_en & (fw_addr == `LBD_F_STATUS)) begin
            st_nxt.zero = fw_data[2];
            st_nxt.digit_carry_flag = fw_data[1];
            st_nxt.carry = fw_data[0];
        end
        if (exec & upd_z) begin
            st_nxt.zero = (res == 8'h00);
        end
        if (exec & upd_cdc) begin
            st_nxt.carry = cy;
            st_nxt.digit_carry_flag = dcy;
        end
        // RL8 standby flag update
        if (exec & (op == LBD_OP_SLEEP)) begin
            st_nxt.watchdog_expiry_flag = 1'b1;
            st_nxt.sleep_entered_flag = 1'b0;
        end
        // RL19 restart sets both
        if (exec & (op == LBD_OP_WDT_RST)) begin
            st_nxt.watchdog_expiry_flag = 1'b1;
            st_nxt.sleep_entered_flag = 1'b1;
        end else if (wdt_ov) begin
            st_nxt.watchdog_expiry_flag = 1'b0;
        end
    end

    // Core state registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r      <= 8'h00;
            status_r   <= `LBD_ST_RESET;
            pc_r       <= 13'h0000;
            pc_high_latch_r   <= 5'h00;
            port_lat_r <= 8'h00;
            port_dir_r <= `LBD_PDIR_RESET;
            psa_r      <= 1'b0;
            faddr_r    <= 7'h00;
            sp_r       <= '0;
        end else begin
            status_r <= st_nxt;
            if (exec & w_acc) begin
                acc_r <= res;
            end else if (bus_wr & (dph_addr_r == `LBD_A_ACC)) begin
                acc_r <= hwdata[7:0];
            end
            // RL11 pc advance and branches
            if (exec) begin
                pc_r <= pc_nxt;
            end else if (bus_wr & (dph_addr_r == `LBD_A_PC)) begin
                pc_r <= hwdata[12:0];
            end
            // RL3 stack push
            if (exec & push) begin
                sp_r <= SP_W'(sp_r + 1'b1);
            end else if (exec & pop) begin
                sp_r <= SP_W'(sp_r - 1'b1);
            end
            if (fw_en & (fw_addr == `LBD_F_PCHI)) begin
                pc_high_latch_r <= fw_data[4:0];
            end
            if (fw_en & (fw_addr == `LBD_F_PORT)) begin
                port_lat_r <= fw_data;
            end
            if (bus_wr & (dph_addr_r == `LBD_A_PDIR)) begin
                port_dir_r <= hwdata[7:0];
            end
            if (bus_wr & (dph_addr_r == `LBD_A_CTRL)) begin
                psa_r <= hwdata[`LBD_CTRL_PSA];
            end
            if (bus_wr & (dph_addr_r == `LBD_A_FADDR)) begin
                faddr_r <= hwdata[6:0];
            end
        end
    end

    // Timer0, shared prescaler and watchdog counter.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer0_r <= 8'h00;
            presc_r  <= '0;
            wdt_r    <= '0;
            sleep_r  <= 1'b0;
        end else begin
            presc_r <= presc_clr ? '0 : PRESC_W'(presc_r + 1'b1);
            if (tmr_wr) begin
                timer0_r <= fw_data;
            end else if (psa_r | presc_ov) begin
                timer0_r <= timer0_r + 8'h01;
            end
            // RL19 watchdog counter zeroed
            if (exec & (op == LBD_OP_WDT_RST)) begin
                wdt_r <= '0;
            end else if (wdt_tick) begin
                wdt_r <= WDT_W'(wdt_r + 1'b1);
            end
            // RL8 standby entry; software wakes it through the control register.
            if (exec & (op == LBD_OP_SLEEP)) begin
                sleep_r <= 1'b1;
            end else if (bus_wr & (dph_addr_r == `LBD_A_CTRL)) begin
                sleep_r <= sleep_r & hwdata[`LBD_CTRL_STBY];
            end
        end
    end

    // Read selection for the data phase.
    wire [31:0] rd_mux =
        (dph_addr_r == `LBD_A_ACC)    ? {24'h00_0000, acc_r} :
        (dph_addr_r == `LBD_A_STATUS) ? {27'h000_0000, status_r} :
        (dph_addr_r == `LBD_A_PC)     ? {19'h0_0000, pc_r} :
        (dph_addr_r == `LBD_A_CTRL)   ? {30'h0000_0000, sleep_r, psa_r} :
        (dph_addr_r == `LBD_A_PDIR)   ? {24'h00_0000, port_dir_r} :
        (dph_addr_r == `LBD_A_FADDR)  ? {25'h000_0000, faddr_r} :
        (dph_addr_r == `LBD_A_FDATA)  ? {24'h00_0000, fdata} :
        (dph_addr_r == `LBD_A_TIMERS) ? {8'h00, 8'(wdt_r), 8'(presc_r), timer0_r} :
        (dph_addr_r == `LBD_A_STACK)  ? {16'h0000, 3'h0, stack_mem[SP_W'(sp_r - 1'b1)]} :
        32'h0000_0000;

    // Reads take one wait; a two-cycle instruction stalls the next transfer one cycle.
    // RL11 idle second cycle
    wire hready_nxt = ~((addr_take & ~hwrite) | (exec & two_cyc));

    // Bus slave registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_r    <= 1'b0;
            dph_rd_r    <= 1'b0;
            dph_addr_r  <= 8'h00;
            hreadyout_r <= 1'b1;
            hrdata_r    <= 32'h0000_0000;
        end else begin
            if (hready) begin
                dph_wr_r   <= addr_take & hwrite;
                dph_rd_r   <= addr_take & ~hwrite;
                dph_addr_r <= addr_take ? {haddr[7:2], 2'b00} : dph_addr_r;
            end
            hreadyout_r <= hready_nxt;
            if (~hreadyout_r & dph_rd_r) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = 1'b0;
    assign port_out  = port_lat_r;
    assign port_oe_n = port_dir_r;
    assign standby   = sleep_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    lit_add_a: assert property (exec && op == LBD_OP_ADD_LIT |=> // RL1
        acc_r == $past(sum9[7:0]) && status_r.carry == $past(sum9[8]))
        else $error("Literal add result or carry wrong.");
    lit_and_a: assert property (exec && op == LBD_OP_AND_LIT |=> // RL2
        acc_r == ($past(acc_r) & $past(k8)) && $stable(status_r.carry))
        else $error("Literal AND result or flags wrong.");
    call_target_a: assert property (exec && op == LBD_OP_CALL |=> // RL3
        pc_r == {$past(pc_high_latch_r[4:3]), $past(k11)} && !hreadyout_r ##1 hreadyout_r)
        else $error("Call target or cycle count wrong.");
    lit_or_a: assert property (exec && op == LBD_OP_OR_LIT |=> // RL4
        hreadyout_r && acc_r == ($past(acc_r) | $past(k8)))
        else $error("Literal OR wrong or took two cycles.");
    lit_sub_a: assert property (exec && op == LBD_OP_SUB_LIT |=> // RL6
        acc_r == $past(k8) - $past(acc_r))
        else $error("Literal minus accumulator wrong.");
    sleep_flags_a: assert property (exec && op == LBD_OP_SLEEP |=> // RL8
        sleep_r && !status_r.sleep_entered_flag && status_r.watchdog_expiry_flag)
        else $error("Standby entry flags wrong.");
    presc_clear_a: assert property (tmr_wr && !psa_r |=> presc_r == '0) // RL10
        else $error("Prescaler not cleared on timer0 write.");
    skip_clr_a: assert property (exec && op == LBD_OP_SKIP_CLR && !bval |=> // RL16
        pc_r == $past(pc_r) + 13'h0002 && !hreadyout_r)
        else $error("Skip on clear bit did not skip.");
    skip_set_a: assert property (exec && op == LBD_OP_SKIP_SET && !bval |=> // RL17
        pc_r == $past(pc_r) + 13'h0001 && hreadyout_r)
        else $error("Skip on set bit skipped wrongly.");
    clr_zero_a: assert property (exec && op == LBD_OP_CLR_FILE |=> status_r.zero) // RL18
        else $error("File clear did not set zero.");
    wdt_restart_a: assert property (exec && op == LBD_OP_WDT_RST |=> // RL19
        wdt_r == '0 && status_r.watchdog_expiry_flag && status_r.sleep_entered_flag)
        else $error("Watchdog restart effects wrong.");
endmodule
`default_nettype wire

// *** verification/lbd_pin_model.sv ***
// Pin-side model that drives the port input pins.
`timescale 1ns/100ps
`default_nettype none
module lbd_pin_model (
    input  wire logic [7:0] drv,
    input  wire logic [7:0] oe_n,
    output logic      [7:0] pins
);
    // Driven pins follow the latch; undriven pins show its inverse, so a read of
    // the latch in place of the pin level is caught.
    assign pins = (drv & ~oe_n) | (~drv & oe_n);
endmodule
`default_nettype wire

// *** verification/test_literal_bit_op_decoder.sv ***
// Self-checking bench for the literal and bit operation decoder.
`timescale 1ns/100ps
`default_nettype none
`include "lbd_defs.svh"
module test_literal_bit_op_decoder;
    import lbd_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, standby;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, rnd = 96;
    logic [1:0] htrans = 0;
    logic [7:0] port_pins_in, port_out, port_oe_n;
    int num_errors = 0, n_tests = 0, w = 0, c = 0, dc = 0, zf = 0, pc = 0, k, s, v, t;
    lbd_core lbd_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_pins_in(port_pins_in),
        .port_out(port_out), .port_oe_n(port_oe_n), .standby(standby));
    lbd_pin_model lbd_pin_model_i (.drv(port_out), .oe_n(port_oe_n), .pins(port_pins_in));
    initial forever #2 hclk = ~hclk;
    // Prints the counts and the verdict, then ends the run.
    task finish_test;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Waits for hready; a bound stops a hung slave from stalling the run.
    task hwait;
        int i;
        i = 0;
        do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 40);
        if (i >= 40) begin num_errors++; finish_test; end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0, a};
        hwait;
        htrans <= 0; hsel <= 0; hwdata <= d;
        hwait;
        rd = hrdata;
    endtask
    task op(input int instr);
        bus(1, `LBD_A_INSTR, instr);
        pc = pc + 1;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13; x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        bus(1, `LBD_A_PC, 0); bus(1, `LBD_A_FADDR, `LBD_F_PCHI); bus(1, `LBD_A_FDATA, 0);
        // Literal operations against the integer accumulator model.
        for (t = 0; t < 24; t++) begin
            rnd = xs(rnd); k = rnd[7:0];
            case (t % 6)
                0: begin op('h3E00 | k); s = w + k; dc = (w % 16 + k % 16) / 16; end
                1: begin op('h3C00 | k); s = k + 256 - w; dc = (k % 16 + 16 - w % 16) / 16; end
                2: begin op('h3900 | k); w = w & k; end
                3: begin op('h3800 | k); w = w | k; end
                4: begin op('h3A00 | k); w = w ^ k; end
                default: begin op('h3000 | k); w = k; end
            endcase
            if (t % 6 < 2) begin c = s / 256; w = s % 256; end
            if (t % 6 < 5) zf = (w == 0);
            bus(0, `LBD_A_ACC, 0); chk(rd, w);
            bus(0, `LBD_A_STATUS, 0); chk(rd[2:0], {zf[0], dc[0], c[0]});
        end
        rnd = xs(rnd); v = rnd[7:0];
        bus(1, `LBD_A_FADDR, 'h20); bus(1, `LBD_A_FDATA, v);
        // Each bit is tested both ways; a true skip costs one extra count.
        for (t = 0; t < 8; t++) begin
            op('h1800 | t << 7 | 'h20); if (!v[t]) pc++;
            op('h1C00 | t << 7 | 'h20); if (v[t]) pc++;
        end
        bus(0, `LBD_A_PC, 0); chk(rd, pc);
        op('h16A0); op('h1020); v = (v | 32) & 254;
        bus(0, `LBD_A_FDATA, 0); chk(rd, v);
        bus(0, `LBD_A_STATUS, 0); chk(rd[2:0], {zf[0], dc[0], c[0]});
        op('h07A0); s = (w + v) % 256;
        bus(0, `LBD_A_FDATA, 0); chk(rd, s);
        op('h0520); w = w & s;
        bus(0, `LBD_A_ACC, 0); chk(rd, w);
        op('h01A0); bus(0, `LBD_A_FDATA, 0); chk(rd, 0);
        bus(0, `LBD_A_STATUS, 0); chk(rd[2], 1);
        op('h2123); s = pc; pc = 'h123;
        bus(0, `LBD_A_STACK, 0); chk(rd, s);
        bus(0, `LBD_A_PC, 0); chk(rd, pc);
        op(`LBD_W_RET); bus(0, `LBD_A_PC, 0); chk(rd, s);
        op('h2855); bus(0, `LBD_A_PC, 0); chk(rd, 'h55);
        // Timer0 write clears the prescaler; the one read wait lets it count once.
        bus(1, `LBD_A_FADDR, `LBD_F_TIMER0); bus(1, `LBD_A_FDATA, 'h3C);
        bus(0, `LBD_A_TIMERS, 0); chk(rd[15:0], 'h013C);
        // Input pins show the inverse of the latch, so a latch read would give A5.
        bus(1, `LBD_A_PDIR, 'h0F); bus(1, `LBD_A_FADDR, `LBD_F_PORT);
        bus(1, `LBD_A_FDATA, 'hA5); op('h30FF); w = 'hFF; op('h0586);
        @(posedge hclk); chk(port_out, 'hAA); chk(port_oe_n, 'h0F);
        // A word written in standby is refused and leaves the accumulator alone.
        op(`LBD_W_SLEEP); op('h3000); chk(standby, 1);
        bus(1, `LBD_A_CTRL, 0); @(posedge hclk); chk(standby, 0);
        bus(0, `LBD_A_ACC, 0); chk(rd, w);
        op(`LBD_W_WDTR); bus(0, `LBD_A_TIMERS, 0); chk(rd[23:16], 1);
        bus(0, `LBD_A_STATUS, 0); chk(rd[4:3], 3);
        finish_test;
    end
endmodule
`default_nettype wire
